// ==== rtl/tea_pkg.sv ====
// shared constants and types for the event timer block
package tea_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLOCK_SELECT_ENABLE_CTRL   = 6'h00;
  localparam logic [5:0] IDX_WAVEFORM_CHANNEL_CTRL   = 6'h01;
  localparam logic [5:0] IDX_OUTPUT_VALUE_CTRL   = 6'h02;
  localparam logic [5:0] IDX_SPLIT_MODE_CTRL   = 6'h03;
  localparam logic [5:0] IDX_ECLR    = 6'h04;
  localparam logic [5:0] IDX_ESET    = 6'h05;
  localparam logic [5:0] IDX_FCLR    = 6'h06;
  localparam logic [5:0] IDX_FSET    = 6'h07;
  localparam logic [5:0] IDX_EVENT_INPUT_CONTROL  = 6'h09;
  localparam logic [5:0] IDX_INTEN   = 6'h0A;
  localparam logic [5:0] IDX_INTFLG  = 6'h0B;
  localparam logic [5:0] IDX_DBG     = 6'h0E;
  localparam logic [5:0] IDX_TEMP    = 6'h0F;
  localparam logic [5:0] IDX_CNT     = 6'h20;
  localparam logic [5:0] IDX_PER     = 6'h26;
  localparam logic [5:0] IDX_CHANNEL0_MATCH    = 6'h28;
  localparam logic [5:0] IDX_CHANNEL1_MATCH    = 6'h2A;
  localparam logic [5:0] IDX_CHANNEL2_MATCH    = 6'h2C;
  localparam logic [5:0] IDX_PERIOD_BUFFER  = 6'h36;
  localparam logic [5:0] IDX_COMPARE0_BUFFER = 6'h38;
  localparam logic [5:0] IDX_COMPARE1_BUFFER = 6'h3A;
  localparam logic [5:0] IDX_COMPARE2_BUFFER = 6'h3C;
  // field positions
  localparam int EN_BIT     = 0;
  localparam int CLKSEL_LSB = 1;
  localparam int DIR_BIT    = 0;
  localparam int LUPD_BIT   = 1;
  localparam int CMD_LSB    = 2;
  localparam int COUNT_ON_EVENT_ENABLE_BIT  = 0;
  localparam int EVENT_ACTION_SELECT_LSB  = 1;
  localparam int FLG_WRAP   = 0;
  localparam int FLG_HIGH_BYTE_UNDERFLOW   = 1;
  localparam int FLG_CMP    = 4;
  localparam int RUN_WHILE_HALTED_BIT = 0;
  // implemented flag and enable bits
  localparam logic [7:0]  FLG_MASK = 8'h73;
  // reset values
  localparam logic [7:0]  RST8     = 8'h00;
  localparam logic [15:0] RST16    = 16'h0000;
  localparam logic [15:0] PER_RST  = 16'hFFFF;
  localparam logic [9:0]  PRE_RST  = 10'h000;
  // event actions
  typedef enum logic [1:0] {
    EV_POS  = 2'b00,
    EV_ANY  = 2'b01,
    EV_HIGH = 2'b10,
    EV_UPDN = 2'b11
  } tea_event_action_select_e;
  // commands in the set-type control register
  typedef enum logic [1:0] {
    CMD_NONE    = 2'b00,
    CMD_UPDATE  = 2'b01,
    CMD_RESTART = 2'b10,
    CMD_RESET   = 2'b11
  } tea_cmd_e;
endpackage

// ==== rtl/tea_irq_if.sv ====
// flag set/clear and mask signals between timer core and flag block
`timescale 1ns/1ps
interface tea_irq_if;
  logic [7:0] set;    // hardware events, one-cycle pulses
  logic [7:0] clr;    // write-one-to-clear data
  logic [7:0] mask;   // enable bits, same layout as flags
  logic [7:0] flags;  // sticky flags
  modport core (input set, input clr, input mask, output flags);
  modport user (output set, output clr, output mask, input flags);
endinterface

// ==== rtl/tea_evt.sv ====
// event input synchroniser and action decoder
`timescale 1ns/1ps
module tea_evt (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       evt_pin,
  input  wire logic [1:0] act,
  input  wire logic       tick,
  output logic            step,
  output logic            down
);
  logic s1_r, s2_r, prev_r;  // two-stage sync, then history
  wire  rise = s2_r & ~prev_r;
  wire  fall = ~s2_r & prev_r;

  // s1_r only feeds s2_r
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      s1_r   <= evt_pin;
      s2_r   <= s1_r;
      prev_r <= s2_r;
    end
  end

  // edge actions ignore the prescaler; level actions use it
  assign step = (act == tea_pkg::EV_POS)  ? rise :
                (act == tea_pkg::EV_ANY)  ? rise | fall :
                (act == tea_pkg::EV_HIGH) ? tick & s2_r :
                tick;
  assign down = s2_r;  // high level counts down

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_rise_step: assert property ((act == tea_pkg::EV_POS) && rise |-> step)
    else $error("rising edge not counted");
  a_fall_step: assert property ((act == tea_pkg::EV_ANY) && fall |-> step)
    else $error("falling edge not counted");
  a_gate_low: assert property ((act == tea_pkg::EV_HIGH) && !s2_r |-> !step)
    else $error("gated count while low");
endmodule

// ==== rtl/tea_irq.sv ====
// sticky interrupt flags, mask and request output
`timescale 1ns/1ps
module tea_irq (
  input  wire logic clk,
  input  wire logic srst,
  tea_irq_if.core   bus,
  output logic      irq
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // hardware set wins over a same-cycle software clear
  assign flags_nxt = ((flags_r & ~bus.clr) | bus.set) & tea_pkg::FLG_MASK;

  always_ff @(posedge clk) begin
    if (srst) flags_r <= tea_pkg::RST8;
    else      flags_r <= flags_nxt;
  end

  assign bus.flags = flags_r;
  assign irq = |(flags_r & bus.mask);

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_set_wins: assert property (bus.set[0] |=> flags_r[0])
    else $error("wrap flag not set");
  a_w1c_clear: assert property
    (flags_r[4] && bus.clr[4] && !bus.set[4] |=> !flags_r[4])
    else $error("flag not cleared by one");
  a_req_held: assert property
    (flags_r[5] && bus.mask[5] && !bus.clr[5] |=> irq)
    else $error("request dropped while flag set");
  c_irq_seen: cover property (irq ##1 !irq);
endmodule

// ==== rtl/tea_top.sv ====
// timer with event input, interrupt flags and an AHB-Lite register map
`timescale 1ns/1ps
module tea_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        evt_in,
  input  wire logic        sleep,
  input  wire logic        dbg_halt,
  output logic             irq
);
  // bus data-phase state
  logic        wp_r;          // write data phase pending
  logic [5:0]  widx_r;        // index of pending write
  logic [31:0] hrdata_r;      // read data, captured at address phase
  // control registers
  logic        en_r;
  logic [2:0]  clksel_r;
  logic [6:0]  waveform_channel_ctrl_r;       // stored only, waveform logic lives elsewhere
  logic [2:0]  output_value_ctrl_r;
  logic        split_r;
  logic        dir_r;
  logic        lupd_r;
  logic [3:0]  bv_r;          // buffer valid: channel2_match..channel0_match, period
  logic        count_on_event_enable_r;
  logic [1:0]  event_action_select_r;
  logic [7:0]  inten_r;
  logic        run_while_halted_r;
  logic [7:0]  temp_r;
  // count datapath
  logic [15:0] cnt_r;
  logic [15:0] per_r;
  logic [15:0] period_buffer_r;
  logic [15:0] cmp_r  [3];
  logic [15:0] cbuf_r [3];
  logic [9:0]  pre_r;         // prescaler
  logic [15:0] cnt_nxt;
  logic [7:0]  hw_set;
  logic        wrap;

  tea_irq_if irq_bus ();

  // address phase take and write strobes
  wire ap_take = hsel & htrans[1] & hready;
  wire [5:0] aidx = haddr[7:2];
  wire amap = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
  wire [7:0] wd8 = hwdata[7:0];

  function automatic logic hit(input logic p, input logic [5:0] a,
                               input logic [5:0] b);
    hit = p & (a == b);
  endfunction

  // prescale mask: tick when the masked bits are all zero
  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    div_mask = 10'h000;
      3'h1:    div_mask = 10'h001;
      3'h2:    div_mask = 10'h003;
      3'h3:    div_mask = 10'h007;
      3'h4:    div_mask = 10'h00F;
      3'h5:    div_mask = 10'h03F;
      3'h6:    div_mask = 10'h0FF;
      default: div_mask = 10'h3FF;
    endcase
  endfunction

  wire w_clock_select_enable_ctrl = hit(wp_r, widx_r, tea_pkg::IDX_CLOCK_SELECT_ENABLE_CTRL);
  wire w_waveform_channel_ctrl = hit(wp_r, widx_r, tea_pkg::IDX_WAVEFORM_CHANNEL_CTRL);
  wire w_output_value_ctrl = hit(wp_r, widx_r, tea_pkg::IDX_OUTPUT_VALUE_CTRL);
  wire w_split_mode_ctrl = hit(wp_r, widx_r, tea_pkg::IDX_SPLIT_MODE_CTRL);
  wire w_eclr  = hit(wp_r, widx_r, tea_pkg::IDX_ECLR);
  wire w_eset  = hit(wp_r, widx_r, tea_pkg::IDX_ESET);
  wire w_fclr  = hit(wp_r, widx_r, tea_pkg::IDX_FCLR);
  wire w_fset  = hit(wp_r, widx_r, tea_pkg::IDX_FSET);
  wire w_ev    = hit(wp_r, widx_r, tea_pkg::IDX_EVENT_INPUT_CONTROL);
  wire w_inten = hit(wp_r, widx_r, tea_pkg::IDX_INTEN);
  wire w_flg   = hit(wp_r, widx_r, tea_pkg::IDX_INTFLG);
  wire w_dbg   = hit(wp_r, widx_r, tea_pkg::IDX_DBG);
  wire w_temp  = hit(wp_r, widx_r, tea_pkg::IDX_TEMP);
  wire w_cnt   = hit(wp_r, widx_r, tea_pkg::IDX_CNT);
  wire w_per   = hit(wp_r, widx_r, tea_pkg::IDX_PER);
  wire w_pbuf  = hit(wp_r, widx_r, tea_pkg::IDX_PERIOD_BUFFER);
  wire [2:0] w_cmp  = {hit(wp_r, widx_r, tea_pkg::IDX_CHANNEL2_MATCH),
                       hit(wp_r, widx_r, tea_pkg::IDX_CHANNEL1_MATCH),
                       hit(wp_r, widx_r, tea_pkg::IDX_CHANNEL0_MATCH)};
  wire [2:0] w_cbuf = {hit(wp_r, widx_r, tea_pkg::IDX_COMPARE2_BUFFER),
                       hit(wp_r, widx_r, tea_pkg::IDX_COMPARE1_BUFFER),
                       hit(wp_r, widx_r, tea_pkg::IDX_COMPARE0_BUFFER)};

  // commands issued through the set-type register
  wire [1:0] cmd = wd8[tea_pkg::CMD_LSB +: 2];
  wire cmd_upd = w_eset & (cmd == tea_pkg::CMD_UPDATE);
  wire cmd_rst = w_eset & (cmd == tea_pkg::CMD_RESTART);

  // run qualification: sleep always halts, debug halt unless allowed
  wire halt = sleep | (dbg_halt & ~run_while_halted_r);
  wire run  = en_r & ~halt;
  wire tick = run & ((pre_r & div_mask(clksel_r)) == 10'h000);

  // event path; dual mode and a clear enable bit bypass it
  logic ev_step;
  logic ev_down;
  tea_evt u_evt (
    .clk     (clk),
    .srst    (srst),
    .evt_pin (evt_in),
    .act     (event_action_select_r),
    .tick    (tick),
    .step    (ev_step),
    .down    (ev_down)
  );
  wire ev_on = count_on_event_enable_r & ~split_r;
  wire step  = ev_on ? (ev_step & run) : tick;
  wire down  = (ev_on & (event_action_select_r == tea_pkg::EV_UPDN)) ? ev_down
                                                       : dir_r;

  // next count and hardware flag events
  always_comb begin
    cnt_nxt = cnt_r;
    hw_set  = 8'h00;
    wrap    = 1'b0;
    if (split_r) begin
      if (tick) begin
        // two independent down counters reloading from period bytes
        cnt_nxt[7:0]  = (cnt_r[7:0] == 8'h00) ? per_r[7:0]
                                              : cnt_r[7:0] - 8'h01;
        cnt_nxt[15:8] = (cnt_r[15:8] == 8'h00) ? per_r[15:8]
                                               : cnt_r[15:8] - 8'h01;
        hw_set[tea_pkg::FLG_WRAP] = (cnt_r[7:0] == 8'h00);
        hw_set[tea_pkg::FLG_HIGH_BYTE_UNDERFLOW] = (cnt_r[15:8] == 8'h00);
        for (int i = 0; i < 3; i++) begin
          // only low byte compares flag
          hw_set[tea_pkg::FLG_CMP + i] = (cnt_r[7:0] == cmp_r[i][7:0]);
        end
      end
    end else if (step) begin
      if (down) begin
        wrap    = (cnt_r == 16'h0000);
        cnt_nxt = wrap ? per_r : cnt_r - 16'h0001;
      end else begin
        wrap    = (cnt_r == per_r);
        cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;
      end
      hw_set[tea_pkg::FLG_WRAP] = wrap;
      for (int i = 0; i < 3; i++) begin
        hw_set[tea_pkg::FLG_CMP + i] = (cnt_r == cmp_r[i]);
      end
    end
  end

  // buffer transfer at wrap unless locked or in dual mode; command forces it
  wire do_upd = (wrap & ~lupd_r & ~split_r) | cmd_upd;
  wire [3:0] bv_wr = {w_cbuf, w_pbuf};
  wire [3:0] bv_nxt = ((bv_r & ~{4{do_upd}}) & ~({4{w_fclr}} & wd8[3:0]))
                      | ({4{w_fset}} & wd8[3:0]) | bv_wr;

  // flag block hookup
  assign irq_bus.set  = hw_set;
  assign irq_bus.clr  = w_flg ? wd8 : 8'h00;
  assign irq_bus.mask = inten_r;
  tea_irq u_irq (
    .clk  (clk),
    .srst (srst),
    .bus  (irq_bus),
    .irq  (irq)
  );

  // bus phase tracking and read capture
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r     <= 1'b0;
      widx_r   <= 6'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wp_r   <= ap_take & hwrite & amap;
      widx_r <= aidx;
      if (ap_take & ~hwrite) hrdata_r <= amap ? rd_word(aidx) : 32'h0;
    end
  end

  // read selection; clear and set registers read the same status
  function automatic logic [31:0] rd_word(input logic [5:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      tea_pkg::IDX_CLOCK_SELECT_ENABLE_CTRL:   v = {12'h000, clksel_r, en_r};
      tea_pkg::IDX_WAVEFORM_CHANNEL_CTRL:   v = {9'h000, waveform_channel_ctrl_r};
      tea_pkg::IDX_OUTPUT_VALUE_CTRL:   v = {13'h0000, output_value_ctrl_r};
      tea_pkg::IDX_SPLIT_MODE_CTRL:   v = {15'h0000, split_r};
      tea_pkg::IDX_ECLR,
      tea_pkg::IDX_ESET:    v = {14'h0000, lupd_r, dir_r};
      tea_pkg::IDX_FCLR,
      tea_pkg::IDX_FSET:    v = {12'h000, bv_r};
      tea_pkg::IDX_EVENT_INPUT_CONTROL:  v = {13'h0000, event_action_select_r, count_on_event_enable_r};
      tea_pkg::IDX_INTEN:   v = {8'h00, inten_r};
      tea_pkg::IDX_INTFLG:  v = {8'h00, irq_bus.flags};
      tea_pkg::IDX_DBG:     v = {15'h0000, run_while_halted_r};
      tea_pkg::IDX_TEMP:    v = {8'h00, temp_r};
      tea_pkg::IDX_CNT:     v = cnt_r;
      tea_pkg::IDX_PER:     v = per_r;
      tea_pkg::IDX_CHANNEL0_MATCH:    v = cmp_r[0];
      tea_pkg::IDX_CHANNEL1_MATCH:    v = cmp_r[1];
      tea_pkg::IDX_CHANNEL2_MATCH:    v = cmp_r[2];
      tea_pkg::IDX_PERIOD_BUFFER:  v = period_buffer_r;
      tea_pkg::IDX_COMPARE0_BUFFER: v = cbuf_r[0];
      tea_pkg::IDX_COMPARE1_BUFFER: v = cbuf_r[1];
      tea_pkg::IDX_COMPARE2_BUFFER: v = cbuf_r[2];
      default:              v = 16'h0000;
    endcase
    rd_word = {16'h0000, v};
  endfunction

  // control registers; software write wins over hardware update
  always_ff @(posedge clk) begin
    if (srst) begin
      en_r     <= 1'b0;
      clksel_r <= 3'h0;
      waveform_channel_ctrl_r  <= 7'h00;
      output_value_ctrl_r  <= 3'h0;
      split_r  <= 1'b0;
      dir_r    <= 1'b0;
      lupd_r   <= 1'b0;
      bv_r     <= 4'h0;
      count_on_event_enable_r  <= 1'b0;
      event_action_select_r  <= 2'b00;
      inten_r  <= tea_pkg::RST8;
      run_while_halted_r <= 1'b0;
      temp_r   <= tea_pkg::RST8;
    end else begin
      if (w_clock_select_enable_ctrl) {clksel_r, en_r} <= wd8[3:0];
      if (w_waveform_channel_ctrl) waveform_channel_ctrl_r <= wd8[6:0];
      if (w_output_value_ctrl) output_value_ctrl_r <= wd8[2:0];
      if (w_split_mode_ctrl) split_r <= wd8[0];
      if (w_ev) begin
        count_on_event_enable_r <= wd8[tea_pkg::COUNT_ON_EVENT_ENABLE_BIT];
        event_action_select_r <= wd8[tea_pkg::EVENT_ACTION_SELECT_LSB +: 2];
      end
      if (w_inten) inten_r <= wd8 & tea_pkg::FLG_MASK;
      if (w_dbg)   run_while_halted_r <= wd8[tea_pkg::RUN_WHILE_HALTED_BIT];
      if (w_temp)  temp_r <= wd8;
      // one clears, zero leaves; restart also clears direction
      if (w_eclr | cmd_rst)
        dir_r <= dir_r & ~(wd8[tea_pkg::DIR_BIT] | cmd_rst);
      else if (w_eset)
        dir_r <= dir_r | wd8[tea_pkg::DIR_BIT];
      if (w_eclr)
        lupd_r <= lupd_r & ~wd8[tea_pkg::LUPD_BIT];
      else if (w_eset)
        lupd_r <= lupd_r | wd8[tea_pkg::LUPD_BIT];
      bv_r <= bv_nxt;
    end
  end

  // count, period, compare and buffers
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r    <= tea_pkg::RST16;
      per_r    <= tea_pkg::PER_RST;
      period_buffer_r <= tea_pkg::PER_RST;
      pre_r    <= tea_pkg::PRE_RST;
      for (int i = 0; i < 3; i++) begin
        cmp_r[i]  <= tea_pkg::RST16;
        cbuf_r[i] <= tea_pkg::RST16;
      end
    end else begin
      // prescaler stops with the counter, so sleep freezes it too
      if (run) pre_r <= pre_r + 10'h001;
      if (w_cnt)        cnt_r <= hwdata[15:0];
      else if (cmd_rst) cnt_r <= tea_pkg::RST16;
      else              cnt_r <= cnt_nxt;
      if (w_per)                   per_r <= hwdata[15:0];
      else if (do_upd & bv_r[0])   per_r <= period_buffer_r;
      if (w_pbuf) period_buffer_r <= hwdata[15:0];
      for (int i = 0; i < 3; i++) begin
        if (w_cmp[i])                    cmp_r[i] <= hwdata[15:0];
        else if (do_upd & bv_r[i + 1])   cmp_r[i] <= cbuf_r[i];
        if (w_cbuf[i]) cbuf_r[i] <= hwdata[15:0];
      end
    end
  end

  // bus answers: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire quiet = !w_cnt && !cmd_rst;
  a_halt_freeze: assert property (halt && quiet |=> $stable(cnt_r))
    else $error("count moved during sleep");
  a_evt_off: assert property
    (!count_on_event_enable_r && !tick && !split_r && quiet |=> $stable(cnt_r))
    else $error("count moved without tick");
  a_split_noevt: assert property
    (split_r && !tick && quiet |=> $stable(cnt_r))
    else $error("event counted in dual mode");
  a_wrap_flag: assert property
    (!split_r && step && !down && cnt_r == per_r && quiet
     |=> cnt_r == 16'h0000 ##0 irq_bus.flags[tea_pkg::FLG_WRAP])
    else $error("wrap not flagged");
  a_cmp_flag: assert property
    (!split_r && step && cnt_r == cmp_r[1] |=> irq_bus.flags[5])
    else $error("compare 1 not flagged");
  a_high_byte_underflow_flag: assert property
    (split_r && tick && cnt_r[15:8] == 8'h00 |=> irq_bus.flags[1])
    else $error("high underflow not flagged");
  a_dir_count: assert property
    (ev_on && event_action_select_r == tea_pkg::EV_UPDN && tick && !ev_down
     && cnt_r != per_r && quiet |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("event direction up not honoured");
  a_irq_mask: assert property
    (inten_r == 8'h00 && !w_inten |=> !irq)
    else $error("masked source raised request");
  c_wrap: cover property (wrap ##1 irq);
  c_split_unf: cover property (split_r && hw_set[tea_pkg::FLG_HIGH_BYTE_UNDERFLOW]);
  c_evt_step: cover property (ev_on && ev_step && run);
endmodule

// ==== verif/tea_evnet.sv ====
// event network model: pulse trains or a steady level on the event line
`timescale 1ns/1ps
module tea_evnet (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] npls,
  input  wire logic       lvl,
  output logic            evt,
  output logic            busy
);
  logic [2:0] ph_r;    // phase within one pulse, six clocks long
  logic [2:0] left_r;  // pulses still to send
  initial ph_r = 3'h0;
  initial left_r = 3'h0;
  assign busy = (left_r != 3'h0);
  // three clocks high, three low: wider than the synchroniser may lose
  assign evt = busy ? (ph_r < 3'h3) : lvl;
  // start a train when idle, else walk through the pulse phases
  always @(posedge clk) begin
    if (!busy) begin
      left_r <= go ? npls : 3'h0;
      ph_r <= 3'h0;
    end else if (ph_r == 3'h5) begin
      left_r <= left_r - 3'h1;
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end
endmodule

// ==== verif/tb_tea_top.sv ====
// self-checking bench for the event timer and its register map
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_tea_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        sleep = 1'b0;
  logic        go = 1'b0;
  logic [2:0]  npls = 3'h0;
  logic        lvl = 1'b0;
  wire         hready, hresp, evt, busy, irq;
  wire  [31:0] hrdata;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          m_cnt, m_flg, m_per;  // behavioural counter state
  int          m_cmp [3];
  int          n;
  logic [15:0] seed = 16'h14A2;
  logic [31:0] a, b;
  logic [5:0]  ri [7] = '{6'h00, 6'h09, 6'h0A, 6'h0B, 6'h26, 6'h20, 6'h08};
  logic [31:0] rv [7] = '{0, 0, 0, 0, 32'h0000FFFF, 0, 0};
  int          tl [4] = '{0, 1, 0, 1};  // event level per case
  int          ta [4] = '{2, 2, 3, 3};  // gate, gate, direction, direction
  int          tr [4] = '{0, 1, 1, 2};  // 0 hold, 1 up, 2 down

  tea_top dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .evt_in(evt), .sleep(sleep), .dbg_halt(1'b0), .irq(irq));
  tea_evnet evn (.clk(clk), .go(go), .npls(npls), .lvl(lvl), .evt(evt),
    .busy(busy));

  initial forever #4 clk = ~clk;
  // hang guard: the whole run needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // one single transfer; the bench never assumes a wait-state count
  task automatic bus(input logic w, input logic [5:0] ix,
                     input logic [31:0] wd, output logic [31:0] rdv);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1 && k < 100) begin
      k++;
      @(posedge clk);
    end
    rdv = hrdata;
    `CHK("hready", 1'b1, hready)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wr(input logic [5:0] ix, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, ix, wd, d);
  endtask
  task automatic rd(input logic [5:0] ix, output logic [31:0] d);
    bus(1'b0, ix, 32'h0, d);
  endtask
  // ask the event network for a train, then let the synchroniser settle
  task automatic pulses(input logic [2:0] k);
    go <= 1'b1;
    npls <= k;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  // model: compare on the value before the step, wrap after period
  task automatic mstep(input int k);
    for (int i = 0; i < k; i++) begin
      for (int j = 0; j < 3; j++) if (m_cnt == m_cmp[j]) m_flg |= 16 << j;
      if (m_cnt == m_per) begin
        m_cnt = 0;
        m_flg |= 1;
      end else m_cnt++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values, with one unmapped index at the end
    foreach (ri[i]) begin
      rd(ri[i], a);
      `CHK("reset value", rv[i], a)
    end
    seed = lfsr(seed);
    wr(6'h0F, {16'h0, seed});
    rd(6'h0F, a);
    `CHK("temp", {24'h0, seed[7:0]}, a)
    // set/clear pairs: direction bit and period buffer valid
    for (int p = 0; p < 2; p++) begin
      wr(6'h05 + 2 * p, 32'h1);
      rd(6'h04 + 2 * p, a);
      `CHK("clr view", 32'h1, a)
      wr(6'h04 + 2 * p, 32'h0);
      rd(6'h05 + 2 * p, a);
      `CHK("set view", 32'h1, a)
      wr(6'h04 + 2 * p, 32'h1);
      rd(6'h05 + 2 * p, a);
      `CHK("cleared", 32'h0, a)
    end
    // level actions on the prescaled tick, divide by one
    wr(6'h00, 32'h1);
    wr(6'h20, 32'h100);
    for (int i = 0; i < 4; i++) begin
      lvl <= tl[i][0];
      wr(6'h09, {ta[i][1:0], 1'b1});
      repeat (6) @(posedge clk);
      rd(6'h20, a);
      repeat (20) @(posedge clk);
      rd(6'h20, b);
      n = (b > a) ? 1 : (b < a) ? 2 : 0;
      `CHK("level action", tr[i], n)
    end
    // edge actions with compares and a short period
    lvl <= 1'b0;
    wr(6'h09, 32'h1);
    m_per = 3;
    m_cmp = '{1, 2, 5};
    wr(6'h26, 32'h3);
    wr(6'h28, 32'h1);
    wr(6'h2A, 32'h2);
    wr(6'h2C, 32'h5);
    wr(6'h0B, 32'h73);
    m_flg = 0;
    for (int act = 0; act < 2; act++) begin
      wr(6'h09, {act[1:0], 1'b1});
      wr(6'h20, 32'h0);
      m_cnt = 0;
      seed = lfsr(seed);
      n = 1 + seed % 3;
      pulses(n[2:0]);
      mstep(act ? 2 * n : n);
      rd(6'h20, a);
      `CHK("event count", m_cnt, a)
      rd(6'h0B, a);
      `CHK("flags", m_flg, a)
    end
    // mask, raise and clear the request
    wr(6'h0A, 32'h0);
    #1 `CHK("irq masked", 1'b0, irq)
    wr(6'h0A, 32'h10);
    #1 `CHK("irq raised", 1'b1, irq)
    wr(6'h0B, 32'h0);
    #1 `CHK("irq held", 1'b1, irq)
    wr(6'h0B, 32'h10);
    #1 `CHK("irq cleared", 1'b0, irq)
    m_flg &= ~16;
    rd(6'h0B, a);
    `CHK("flags left", m_flg, a)
    // sleep freezes event counting
    rd(6'h20, a);
    sleep <= 1'b1;
    pulses(3'h2);
    rd(6'h20, b);
    `CHK("sleep count", a, b)
    sleep <= 1'b0;
    // events ignored: enable bit clear, then dual 8-bit mode
    wr(6'h00, 32'h0F);
    for (int c = 0; c < 2; c++) begin
      wr(6'h03, c);
      wr(6'h09, c);
      rd(6'h20, a);
      pulses(3'h3);
      rd(6'h20, b);
      `CHK("events ignored", 1'b1, (b - a) != 3)
    end
    summarize();
  end
endmodule
